//--- hw/wdh_map.vh
// Register map and constants for the watchdog / halt / wake-up block
// Assumes byte addressing on a 32-bit AXI4-Lite register bus
`ifndef WDH_MAP_VH
`define WDH_MAP_VH
`define WDH_ADDR_INTERRUPT_CONTROL 8'h08
`define WDH_ADDR_WDOG 8'h0C
`define WDH_ADDR_STAT 8'h10
`define WDH_ADDR_CMD 8'h14
`define WDH_WDOG_RST 8'h07
`define WDH_INTERRUPT_CONTROL_MASK 8'h6D
`define WDH_BIT_MIE 0
`define WDH_BIT_T0E 2
`define WDH_BIT_T1E 3
`define WDH_BIT_T0F 5
`define WDH_BIT_T1F 6
`define WDH_BIT_PD 0
`define WDH_BIT_TO 1
`define WDH_BIT_HALT 2
`define WDH_CMD_CLR 0
`define WDH_CMD_CLR1 1
`define WDH_CMD_CLR2 2
`define WDH_CMD_HALT 3
`define WDH_BASE_BITS 8
`define WDH_WAKE_CYCLES 1024
`define WDH_RESP_OKAY 2'h0
`define WDH_RESP_SLVERR 2'h2
`endif

//--- hw/wdh_top.v
// Watchdog, halt and wake-up controller with AXI4-Lite registers
// Assumes one 50 MHz clock; dog tick and port A pins are asynchronous inputs
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "wdh_map.vh"

// What this block does
// [R1] System clock output is the selected oscillator divided by two.
// [R2] In RC mode the oscillator output pin carries system clock divided by four.
// [R3] Fixed option picks dog clock: dog oscillator or instruction clock.
// [R4] With the dog disabled, all dog operations do nothing.
// [R5] Dog clock first passes a fixed divide-by-256 counter.
// [R6] Setting bits 2..0 select prescaler ratio 1:1 to 1:128.
// [R7] Setting bit 3 and upper nibble are plain user storage.
// [R8] Overflow while running gives full chip reset and sets timeout flag.
// [R9] Overflow while halted gives warm reset of program counter and stack.
// [R10] Reset pin, qualifying clear or halt clear counter and prescaler.
// [R11] Option picks single clear or two-instruction clear pair.
// [R12] Halt stops system oscillator; dog oscillator keeps running.
// [R13] Halt clears dog then it restarts if on dog oscillator.
// [R14] Halt sets power-down flag and clears timeout flag.
// [R15] Power-up or single clear clears power-down; timeout sets timeout flag.
// [R16] Halt indication output is high while halted.
// [R17] Reset, interrupt, port A falling edge or overflow leave halt.
// [R18] Port A bits wake individually by option; resume at next instruction.
// [R19] Interrupt wake resumes unless enabled and stack not full, then services.
// [R20] Wake waits 1024 system clocks; interrupt entry one more cycle.
// [R21] Request flag already set at halt entry cannot wake.
// [R22] Interrupt control: enables bits 0,2,3; requests 5,6; others read zero.
// [R23] Power-up adds 1024-clock start-up delay; reset pin adds none.
// [R24] Port A wake edges are synchronised before use.
module wdh_top #(
    parameter DOG_ENABLE = 1,
    parameter DOG_ON_OSC = 1,
    parameter CLEAR_PAIR = 0,
    parameter RC_OSC = 1,
    parameter [7:0] WAKE_MASK = 8'hFF,
    parameter WAKE_CYCLES = `WDH_WAKE_CYCLES
) (
    input wire I_CLOCK,             // 50 MHz clock
    input wire I_RST_B,             // Async reset, low = power-up
    input wire I_RESET_PIN_B,       // External reset pin, active low

    input wire I_DOG_OSC,           // Free-running dog oscillator (async)
    input wire [7:0] I_PORTA,       // Port A pins (async)
    input wire I_STACK_FULL,        // Core stack is full
    input wire I_T0_EVENT,          // Timer 0 overflow pulse
    input wire I_T1_EVENT,          // Timer 1 overflow pulse
    input wire I_IRQ_ACK,           // Core serviced an interrupt

    // Write channels
    input wire [7:0] S_AXI_AWADDR,  // Write address
    input wire S_AXI_AWVALID,       // Write address valid
    output reg S_AXI_AWREADY,       // Write address ready
    input wire [31:0] S_AXI_WDATA,  // Write data
    input wire [3:0] S_AXI_WSTRB,   // Write strobes
    input wire S_AXI_WVALID,        // Write data valid
    output reg S_AXI_WREADY,        // Write data ready
    output reg [1:0] S_AXI_BRESP,   // Write response
    output reg S_AXI_BVALID,        // Write response valid
    input wire S_AXI_BREADY,        // Write response ready

    // Read channels
    input wire [7:0] S_AXI_ARADDR,  // Read address
    input wire S_AXI_ARVALID,       // Read address valid
    output reg S_AXI_ARREADY,       // Read address ready
    output reg [31:0] S_AXI_RDATA,  // Read data
    output reg [1:0] S_AXI_RRESP,   // Read response
    output reg S_AXI_RVALID,        // Read response valid
    input wire S_AXI_RREADY,        // Read response ready

    // Core side
    output reg O_SYS_CLK_EN,        // System clock tick (osc / 2)
    output reg O_OSC_OUT_PIN,       // Oscillator output pin level
    output reg O_HALT,              // Halted, external memory off
    output reg O_CHIP_RESET,        // Full chip reset pulse
    output reg O_WARM_RESET,        // Clear program counter and stack pointer
    output reg O_CORE_RUN,          // Core may execute
    output reg O_IRQ_TAKE           // Interrupt entry strobe after wake
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    reg [1:0] rst_pin_sync_reg;
    reg [1:0] dog_sync_reg;
    reg [7:0] pa_s1_reg;
    reg [7:0] pa_s2_reg;
    reg [7:0] pa_old_reg;

    reg dog_old_reg;
    always @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            rst_pin_sync_reg <= 2'h3;
            dog_sync_reg <= 2'h0;
            pa_s1_reg <= 8'hFF;
            pa_s2_reg <= 8'hFF;
            pa_old_reg <= 8'hFF;
            dog_old_reg <= 1'b0;
        end else begin
            // Two flip-flops per asynchronous input
            rst_pin_sync_reg <= {rst_pin_sync_reg[0], I_RESET_PIN_B};
            dog_sync_reg <= {dog_sync_reg[0], I_DOG_OSC};
            pa_s1_reg <= I_PORTA;            // [R24]
            pa_s2_reg <= pa_s1_reg;
            pa_old_reg <= pa_s2_reg;
            dog_old_reg <= dog_sync_reg[1];
        end
    end

    wire pin_rst = !rst_pin_sync_reg[1];
    wire [7:0] pa_fall = pa_old_reg & ~pa_s2_reg & WAKE_MASK;  // [R18]
    // One dog tick per rising edge
    wire dog_osc_tick = dog_sync_reg[1] & !dog_old_reg;

    // ------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------
    reg [7:0] interrupt_control_reg;
    reg [7:0] wdog_reg;

    // Flags and sequencing
    reg pd_reg;
    reg to_reg;
    reg halted_reg;
    reg waking_reg;
    reg irq_pend_reg;
    reg [7:0] halt_flags_reg;

    // Counters
    reg [10:0] wake_cnt_reg;
    reg [2:0] sys_div_reg;
    reg first_seen_reg;
    reg [7:0] base_reg;
    reg [7:0] pre_reg;

    // ------------------------------------------------------------
    // Clock derivation
    // ------------------------------------------------------------
    wire sys_tick = sys_div_reg[0];                         // [R1]
    wire instr_tick = sys_div_reg == 3'h7;                  // [R3]
    wire osc_running = !halted_reg;                         // [R12]
    wire dog_tick = (DOG_ON_OSC != 0) ? dog_osc_tick : (instr_tick & osc_running);  // [R3] [R13]

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    wire wr_go = S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID
                 && !S_AXI_AWREADY && S_AXI_WSTRB[0];
    wire wr_any = S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID && !S_AXI_AWREADY;
    // Register selects
    wire wr_interrupt_control = wr_go && S_AXI_AWADDR == `WDH_ADDR_INTERRUPT_CONTROL;
    wire wr_wdog = wr_go && S_AXI_AWADDR == `WDH_ADDR_WDOG;
    wire wr_cmd = wr_go && S_AXI_AWADDR == `WDH_ADDR_CMD;
    // Any implemented register
    wire wr_hit = S_AXI_AWADDR == `WDH_ADDR_INTERRUPT_CONTROL || S_AXI_AWADDR == `WDH_ADDR_WDOG
                  || S_AXI_AWADDR == `WDH_ADDR_STAT || S_AXI_AWADDR == `WDH_ADDR_CMD;

    wire dog_on = DOG_ENABLE != 0;
    // Command strobes, ignored while halted
    wire cmd_clr = wr_cmd && S_AXI_WDATA[`WDH_CMD_CLR] && !halted_reg;
    wire cmd_clr1 = wr_cmd && S_AXI_WDATA[`WDH_CMD_CLR1] && !halted_reg;
    wire cmd_clr2 = wr_cmd && S_AXI_WDATA[`WDH_CMD_CLR2] && !halted_reg;
    wire cmd_halt = wr_cmd && S_AXI_WDATA[`WDH_CMD_HALT] && !halted_reg;

    // Clear scheme: single instruction or any two pair commands
    wire pair_done = (cmd_clr1 && (first_seen_reg == 1'b0) && cmd_clr2)
                     || (first_seen_reg && (cmd_clr1 || cmd_clr2));
    wire qual_clr = dog_on && ((CLEAR_PAIR == 0) ? cmd_clr : pair_done);  // [R11] [R4]

    wire dog_clear = pin_rst || qual_clr || (dog_on && cmd_halt);          // [R10]

    // ------------------------------------------------------------
    // Watchdog counters
    // ------------------------------------------------------------
    wire base_wrap = dog_tick && base_reg == 8'hFF;                         // [R5]
    wire [7:0] pre_lim = (8'h01 << wdog_reg[2:0]) - 8'h01;                  // [R6]

    wire dog_ovf = dog_on && !dog_clear && base_wrap && pre_reg == pre_lim;
    // Overflow outcome depends on halt state
    wire chip_rst = dog_ovf && !halted_reg;                                 // [R8]
    wire warm_rst = dog_ovf && halted_reg;                                  // [R9]

    // ------------------------------------------------------------
    // Wake sources
    // ------------------------------------------------------------
    wire [1:0] req_now = {interrupt_control_reg[`WDH_BIT_T1F], interrupt_control_reg[`WDH_BIT_T0F]};
    wire [1:0] req_wake = req_now & ~{halt_flags_reg[1], halt_flags_reg[0]};  // [R21]

    // Service only if enabled and stack has room
    wire irq_serviceable = interrupt_control_reg[`WDH_BIT_MIE] && !I_STACK_FULL
        && ((req_wake[0] && interrupt_control_reg[`WDH_BIT_T0E]) || (req_wake[1] && interrupt_control_reg[`WDH_BIT_T1E]));
    wire wake = halted_reg && (|pa_fall || |req_wake || warm_rst);          // [R17]

    always @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            interrupt_control_reg <= 8'h00;
            wdog_reg <= `WDH_WDOG_RST;
            pd_reg <= 1'b0;                              // [R15]
            to_reg <= 1'b0;

            halted_reg <= 1'b0;
            waking_reg <= 1'b1;                          // [R23]
            irq_pend_reg <= 1'b0;
            halt_flags_reg <= 8'h00;
            wake_cnt_reg <= 11'h000;
            sys_div_reg <= 3'h0;
            first_seen_reg <= 1'b0;
            base_reg <= 8'h00;
            pre_reg <= 8'h00;

            O_SYS_CLK_EN <= 1'b0;
            O_OSC_OUT_PIN <= 1'b0;
            O_HALT <= 1'b0;
            O_CHIP_RESET <= 1'b0;
            O_WARM_RESET <= 1'b0;
            O_CORE_RUN <= 1'b0;
            O_IRQ_TAKE <= 1'b0;
        end else begin
            sys_div_reg <= osc_running ? sys_div_reg + 3'h1 : sys_div_reg;  // [R12]
            // No tick in the cycle that enters halt
            O_SYS_CLK_EN <= sys_tick && osc_running && !cmd_halt;
            O_OSC_OUT_PIN <= (RC_OSC != 0) ? sys_div_reg[2] : 1'b0;       // [R2]

            O_CHIP_RESET <= chip_rst || pin_rst;
            O_WARM_RESET <= warm_rst;                                     // [R9]
            O_IRQ_TAKE <= 1'b0;

            // Dog counters
            if (dog_clear || chip_rst) begin
                base_reg <= 8'h00;
                pre_reg <= 8'h00;
            end else if (dog_on && dog_tick) begin
                base_reg <= base_reg + 8'h01;
                // Prescaler counts base wraps
                if (base_wrap)
                    pre_reg <= (pre_reg == pre_lim) ? 8'h00 : pre_reg + 8'h01;
            end

            // Pair tracking
            if (dog_clear || CLEAR_PAIR == 0)
                first_seen_reg <= 1'b0;
            else if (cmd_clr1 || cmd_clr2)
                first_seen_reg <= 1'b1;

            // Interrupt control; hardware set wins over software write
            if (pin_rst || chip_rst) begin
                interrupt_control_reg <= 8'h00;
                wdog_reg <= `WDH_WDOG_RST;
            end else begin
                if (wr_interrupt_control)
                    interrupt_control_reg <= S_AXI_WDATA[7:0] & `WDH_INTERRUPT_CONTROL_MASK;      // [R22]
                if (I_T0_EVENT)
                    interrupt_control_reg[`WDH_BIT_T0F] <= 1'b1;
                if (I_T1_EVENT)
                    interrupt_control_reg[`WDH_BIT_T1F] <= 1'b1;
                if (wr_wdog)
                    wdog_reg <= S_AXI_WDATA[7:0];                      // [R6] [R7]
            end

            // Status flags
            if (dog_ovf)
                to_reg <= 1'b1;                                        // [R15] [R8]
            else if (cmd_halt && dog_on)
                to_reg <= 1'b0;                                        // [R14]

            if (cmd_halt && dog_on)
                pd_reg <= 1'b1;                                        // [R14]
            else if (dog_on && cmd_clr)
                pd_reg <= 1'b0;                                        // [R15]
            else if (pin_rst && !halted_reg)
                pd_reg <= pd_reg;

            // Halt and wake sequencing
            if (pin_rst) begin
                // Reset pin: run again at once, no delay
                halted_reg <= 1'b0;                                    // [R17]
                waking_reg <= 1'b0;                                    // [R23]
                irq_pend_reg <= 1'b0;
                O_CORE_RUN <= 1'b0;
                O_HALT <= 1'b0;
            end else if (cmd_halt) begin
                // Enter halt, remember pending requests
                halted_reg <= 1'b1;                                    // [R12]
                halt_flags_reg <= {6'h00, req_now};                    // [R21]
                O_HALT <= 1'b1;                                        // [R16]
                O_CORE_RUN <= 1'b0;
            end else if (wake) begin
                // Leave halt, start the wake delay
                halted_reg <= 1'b0;
                waking_reg <= 1'b1;
                wake_cnt_reg <= 11'h000;
                irq_pend_reg <= irq_serviceable && !warm_rst;          // [R19]
                O_HALT <= 1'b0;
            end else if (waking_reg) begin
                // Count system ticks of the wake delay
                if (sys_tick)
                    wake_cnt_reg <= wake_cnt_reg + 11'h001;
                // Delay over: core may run
                if (sys_tick && wake_cnt_reg == WAKE_CYCLES - 1) begin  // [R20]
                    waking_reg <= 1'b0;
                    O_CORE_RUN <= 1'b1;                                // [R18]
                end
            end else begin
                O_CORE_RUN <= !halted_reg;
                // Interrupt entry one cycle after run
                if (irq_pend_reg) begin
                    O_IRQ_TAKE <= 1'b1;                                // [R20]
                    irq_pend_reg <= 1'b0;
                end
            end

            // Core entered service: drop master enable and one flag
            if (I_IRQ_ACK && !wr_interrupt_control) begin
                interrupt_control_reg[`WDH_BIT_MIE] <= 1'b0;
                if (interrupt_control_reg[`WDH_BIT_T0F] && !I_T0_EVENT)
                    interrupt_control_reg[`WDH_BIT_T0F] <= 1'b0;
                else if (!I_T1_EVENT)
                    interrupt_control_reg[`WDH_BIT_T1F] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite handshakes
    // ------------------------------------------------------------
    always @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= `WDH_RESP_OKAY;

            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RRESP <= `WDH_RESP_OKAY;
            S_AXI_RDATA <= 32'h00000000;
        end else begin
            // Write channel
            S_AXI_AWREADY <= wr_any;
            S_AXI_WREADY <= wr_any;
            if (wr_any) begin
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= wr_hit ? `WDH_RESP_OKAY : `WDH_RESP_SLVERR;
            end else if (S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end

            // Read channel
            S_AXI_ARREADY <= S_AXI_ARVALID && !S_AXI_RVALID && !S_AXI_ARREADY;
            if (S_AXI_ARVALID && !S_AXI_RVALID && !S_AXI_ARREADY) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP <= `WDH_RESP_OKAY;
                case (S_AXI_ARADDR)
                    `WDH_ADDR_INTERRUPT_CONTROL: S_AXI_RDATA <= {24'h000000, interrupt_control_reg};
                    `WDH_ADDR_WDOG: S_AXI_RDATA <= {24'h000000, wdog_reg};
                    `WDH_ADDR_STAT: S_AXI_RDATA <= {29'h00000000, halted_reg, to_reg, pd_reg};
                    `WDH_ADDR_CMD: S_AXI_RDATA <= 32'h00000000;
                    default: begin
                        S_AXI_RDATA <= 32'h00000000;
                        S_AXI_RRESP <= `WDH_RESP_SLVERR;
                    end
                endcase
            end else if (S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

endmodule

//--- sim/wdh_properties.sv
// Checker for the watchdog, halt and wake-up block
// Assumes binding to wdh_top, one clock, async active-low reset
`timescale 1ns/1ps

module wdh_properties #(
    parameter WAKE_CYCLES = 1024
) (
    input wire I_CLOCK,            // Clock
    input wire I_RST_B,            // Power-up reset
    input wire I_RESET_PIN_B,      // Reset pin
    input wire S_AXI_BREADY,       // Write response ready
    input wire [1:0] S_AXI_BRESP,  // Write response
    input wire S_AXI_BVALID,       // Write response valid
    input wire S_AXI_RREADY,       // Read response ready
    input wire [31:0] S_AXI_RDATA, // Read data
    input wire S_AXI_RVALID,       // Read response valid
    input wire O_SYS_CLK_EN,       // System tick
    input wire O_OSC_OUT_PIN,      // Oscillator output pin
    input wire O_HALT,             // Halted
    input wire O_CHIP_RESET,       // Full chip reset
    input wire O_WARM_RESET,       // Warm reset
    input wire O_CORE_RUN,         // Core may run
    input wire O_IRQ_TAKE          // Interrupt entry
);
    localparam int WK_MIN = 2 * WAKE_CYCLES - 2;
    localparam int WK_MAX = 2 * WAKE_CYCLES + 4;
    logic [15:0] gap_cnt_reg;
    logic from_halt_reg;

    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_RST_B);

    // -------------------------------------------------
    // Cycles spent waking after a halt
    // -------------------------------------------------
    always @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            gap_cnt_reg <= 16'h0000;
            from_halt_reg <= 1'h0;
        end else begin
            gap_cnt_reg <= (O_HALT || O_CORE_RUN) ? 16'h0000 : gap_cnt_reg + 16'h0001;
            from_halt_reg <= O_HALT ? 1'h1 : (O_CORE_RUN ? 1'h0 : from_halt_reg);
        end
    end

    property p_halt_no_tick; O_HALT |-> !O_SYS_CLK_EN; endproperty
    a_halt_no_tick: assert property (p_halt_no_tick)
        else $error("system tick while halted");
    property p_tick_pulse; O_SYS_CLK_EN |=> !O_SYS_CLK_EN; endproperty
    a_tick_pulse: assert property (p_tick_pulse)
        else $error("system tick faster than clock over two");
    property p_osc_div; $rose(O_OSC_OUT_PIN) |=> O_OSC_OUT_PIN [*3]; endproperty
    a_osc_div: assert property (p_osc_div)
        else $error("oscillator pin high phase too short");
    property p_halt_stops; O_HALT |-> !O_CORE_RUN; endproperty
    a_halt_stops: assert property (p_halt_stops)
        else $error("core runs while halted");
    property p_warm_halted; O_WARM_RESET |-> $past(O_HALT); endproperty
    a_warm_halted: assert property (p_warm_halted)
        else $error("warm reset outside halt");
    property p_chip_running;
        O_CHIP_RESET && I_RESET_PIN_B && $past(I_RESET_PIN_B) && $past(I_RESET_PIN_B, 2)
            && $past(I_RESET_PIN_B, 3) && $past(I_RESET_PIN_B, 4) |-> !$past(O_HALT);
    endproperty
    a_chip_running: assert property (p_chip_running)
        else $error("chip reset from overflow while halted");
    property p_wake_delay;
        $rose(O_CORE_RUN) && from_halt_reg |-> gap_cnt_reg >= WK_MIN && gap_cnt_reg <= WK_MAX;
    endproperty
    a_wake_delay: assert property (p_wake_delay)
        else $error("wake delay length wrong");
    property p_irq_late;
        O_IRQ_TAKE |-> $past(O_CORE_RUN) && !$past(O_CORE_RUN, 2);
    endproperty
    a_irq_late: assert property (p_irq_late)
        else $error("interrupt entry not one cycle after run");
    property p_b_hold; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
    endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("write response dropped early");
    property p_r_hold; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
    endproperty
    a_r_hold: assert property (p_r_hold)
        else $error("read response dropped early");

    c_warm: cover property (O_WARM_RESET);
    c_irq: cover property (O_IRQ_TAKE);
    c_chip: cover property (O_CHIP_RESET && I_RESET_PIN_B);
endmodule

//--- sim/wdh_core_model.sv
// Far-side model: dog oscillator and core interrupt acknowledge
// Assumes the bench clock; the dog oscillator runs free
`timescale 1ns/1ps

module wdh_core_model (
    input wire i_clock,      // Clock
    input wire i_irq_take,   // Interrupt entry strobe
    input wire i_full_req,   // Bench wants stack full
    output reg o_dog_osc,    // Dog oscillator
    output reg o_irq_ack,    // Interrupt taken
    output wire o_stack_full // Stack full level
);
    assign o_stack_full = i_full_req;
    initial begin
        o_dog_osc = 1'h0;
        o_irq_ack = 1'h0;
        forever #50 o_dog_osc = ~o_dog_osc;
    end
    // Core enters the service routine and acknowledges
    always @(posedge i_clock) begin
        o_irq_ack <= i_irq_take;
    end
endmodule

//--- sim/tb_top.sv
// Register-level bench for the watchdog, halt and wake-up block
// Assumes wdh_top with a shortened wake delay and a free dog oscillator
`timescale 1ns/1ps
`include "wdh_map.vh"

module tb_top;
    logic clk, rst_b, pin_b, t0, t1, full, awv, wv, bry, arv, rry;
    logic [7:0] porta, awa, ara;
    logic [31:0] wd;
    wire awr, wr, bv, arr, rv, dog, ack, stk, tick, osc, halt, chip, warm, run, take;
    wire [1:0] br, rr;
    wire [31:0] rdat;
    int n_mismatch = 0;
    int checked = 0;

    wdh_top #(.WAKE_CYCLES(4)) i_wdh_top (.I_CLOCK(clk), .I_RST_B(rst_b),
        .I_RESET_PIN_B(pin_b), .I_DOG_OSC(dog), .I_PORTA(porta), .I_STACK_FULL(stk),
        .I_T0_EVENT(t0), .I_T1_EVENT(t1), .I_IRQ_ACK(ack), .S_AXI_AWADDR(awa),
        .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF),
        .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(br), .S_AXI_BVALID(bv),
        .S_AXI_BREADY(bry), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
        .S_AXI_RDATA(rdat), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry),
        .O_SYS_CLK_EN(tick), .O_OSC_OUT_PIN(osc), .O_HALT(halt), .O_CHIP_RESET(chip),
        .O_WARM_RESET(warm), .O_CORE_RUN(run), .O_IRQ_TAKE(take));
    wdh_core_model i_wdh_core_model (.i_clock(clk), .i_irq_take(take), .i_full_req(full),
        .o_dog_osc(dog), .o_irq_ack(ack), .o_stack_full(stk));

    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end

    task wrap_up;
        if (n_mismatch == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task to_fail;
        n_mismatch++;
        wrap_up();
    endtask

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task axi_wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        awa <= a;
        wd <= d;
        awv <= 1'h1;
        wv <= 1'h1;
        bry <= 1'h1;
        do begin
            @(posedge clk);
            n++;
            if (awr === 1'h1) awv <= 1'h0;
            if (wr === 1'h1) wv <= 1'h0;
        end while (bv !== 1'h1 && n < 100);
        awv <= 1'h0;
        wv <= 1'h0;
        bry <= 1'h0;
        if (n >= 100) to_fail();
    endtask

    task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        int n;
        n = 0;
        @(posedge clk);
        ara <= a;
        arv <= 1'h1;
        rry <= 1'h1;
        do begin
            @(posedge clk);
            n++;
            if (arr === 1'h1) arv <= 1'h0;
        end while (rv !== 1'h1 && n < 100);
        arv <= 1'h0;
        rry <= 1'h0;
        if (n >= 100) to_fail();
        if (a == 8'h20) chk(nm, {30'h0, rr}, exp);
        else chk(nm, rdat, exp);
    endtask

    task wait_for(input int sel);
        int n;
        logic s;
        n = 0;
        s = 1'h0;
        while (s !== 1'h1 && n < 4000) begin
            @(posedge clk);
            n++;
            case (sel)
                0: s = run;
                1: s = chip;
                2: s = warm;
                default: s = take;
            endcase
        end
        if (s !== 1'h1) to_fail();
    endtask

    task pulse_t(input int which);
        @(posedge clk);
        if (which == 0) t0 <= 1'h1;
        else t1 <= 1'h1;
        @(posedge clk);
        t0 <= 1'h0;
        t1 <= 1'h0;
    endtask

    initial begin
        {rst_b, t0, t1, full, awv, wv, bry, arv, rry} = 9'h000;
        pin_b = 1'h1;
        porta = 8'hFF;
        {awa, ara, wd} = 48'h0;
        repeat (20) @(posedge clk);
        rst_b <= 1'h1;
        wait_for(0);
        rd_chk("wdog", `WDH_ADDR_WDOG, 32'h07);
        rd_chk("interrupt_control", `WDH_ADDR_INTERRUPT_CONTROL, 32'h00);
        rd_chk("stat", `WDH_ADDR_STAT, 32'h00);
        rd_chk("resp", 8'h20, {30'h0, `WDH_RESP_SLVERR});
        axi_wr(`WDH_ADDR_INTERRUPT_CONTROL, 32'hFF);
        rd_chk("interrupt_control", `WDH_ADDR_INTERRUPT_CONTROL, 32'h6D);
        axi_wr(`WDH_ADDR_INTERRUPT_CONTROL, 32'h00);
        pulse_t(1);
        rd_chk("interrupt_control", `WDH_ADDR_INTERRUPT_CONTROL, 32'h40);
        axi_wr(`WDH_ADDR_INTERRUPT_CONTROL, 32'h00);
        axi_wr(`WDH_ADDR_WDOG, 32'hF8);
        rd_chk("wdog", `WDH_ADDR_WDOG, 32'hF8);
        axi_wr(`WDH_ADDR_WDOG, 32'h00);
        axi_wr(`WDH_ADDR_CMD, 32'h08);
        rd_chk("stat", `WDH_ADDR_STAT, 32'h05);
        chk("halt", {31'h0, halt}, 32'h01);
        @(posedge clk);
        porta <= 8'hFE;
        wait_for(0);
        porta <= 8'hFF;
        rd_chk("stat", `WDH_ADDR_STAT, 32'h01);
        axi_wr(`WDH_ADDR_CMD, 32'h01);
        rd_chk("stat", `WDH_ADDR_STAT, 32'h00);
        wait_for(1);
        repeat (4) @(posedge clk);
        wait_for(0);
        rd_chk("stat", `WDH_ADDR_STAT, 32'h02);
        rd_chk("wdog", `WDH_ADDR_WDOG, 32'h07);
        axi_wr(`WDH_ADDR_WDOG, 32'h00);
        axi_wr(`WDH_ADDR_CMD, 32'h08);
        rd_chk("stat", `WDH_ADDR_STAT, 32'h05);
        wait_for(2);
        wait_for(0);
        rd_chk("stat", `WDH_ADDR_STAT, 32'h03);
        rd_chk("wdog", `WDH_ADDR_WDOG, 32'h00);
        axi_wr(`WDH_ADDR_CMD, 32'h01);
        axi_wr(`WDH_ADDR_INTERRUPT_CONTROL, 32'h05);
        axi_wr(`WDH_ADDR_CMD, 32'h08);
        pulse_t(0);
        wait_for(3);
        repeat (3) @(posedge clk);
        rd_chk("interrupt_control", `WDH_ADDR_INTERRUPT_CONTROL, 32'h04);
        axi_wr(`WDH_ADDR_WDOG, 32'h05);
        @(posedge clk);
        pin_b <= 1'h0;
        repeat (4) @(posedge clk);
        pin_b <= 1'h1;
        repeat (4) @(posedge clk);
        rd_chk("wdog", `WDH_ADDR_WDOG, 32'h07);
        wrap_up();
    end
endmodule

bind wdh_top wdh_properties #(.WAKE_CYCLES(WAKE_CYCLES)) i_wdh_properties (.I_CLOCK(I_CLOCK),
    .I_RST_B(I_RST_B), .I_RESET_PIN_B(I_RESET_PIN_B), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_RREADY(S_AXI_RREADY),
    .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID), .O_SYS_CLK_EN(O_SYS_CLK_EN),
    .O_OSC_OUT_PIN(O_OSC_OUT_PIN), .O_HALT(O_HALT), .O_CHIP_RESET(O_CHIP_RESET),
    .O_WARM_RESET(O_WARM_RESET), .O_CORE_RUN(O_CORE_RUN), .O_IRQ_TAKE(O_IRQ_TAKE));
